/* File: rtl/pfrf_pkg.sv */
// pfrf_pkg: register map, field positions and constants of the repair framer
`default_nettype none
package pfrf_pkg;
  localparam int          AW       = 8;
  localparam logic [7:0]  A_CTRL   = 8'h00;
  localparam logic [7:0]  A_GEOM   = 8'h04;
  localparam logic [7:0]  A_SEED   = 8'h08;
  localparam logic [7:0]  A_RSSRC  = 8'h0C;
  localparam logic [7:0]  A_PSSRC  = 8'h10;
  localparam logic [7:0]  A_STAT   = 8'h14;
  localparam logic [7:0]  A_MASK   = 8'h18;
  localparam logic [7:0]  A_CNT    = 8'h1C;
  localparam int          C_EN     = 0;
  localparam int          C_COL    = 1;
  localparam int          C_PAD    = 2;
  localparam int          C_EXT    = 3;
  localparam int          C_PT     = 8;
  localparam int          G_L      = 0;
  localparam int          G_D      = 8;
  localparam int          S_COLL   = 0;
  localparam int          S_VERR   = 1;
  localparam int          S_BUSY   = 2;
  localparam int          S_SEQ    = 16;
  localparam logic [1:0]  RTP_VER  = 2'h2;
  localparam logic [1:0]  FEC_RF   = 2'h1;
  localparam logic [3:0]  REP_CC   = 4'h1;
  localparam logic [7:0]  W_RTP0   = 8'h00;
  localparam logic [7:0]  W_TS     = 8'h01;
  localparam logic [7:0]  W_SSRC   = 8'h02;
  localparam logic [7:0]  W_CSRC   = 8'h03;
  localparam logic [7:0]  W_EXT    = 8'h04;
  localparam logic [7:0]  W_FEC0   = 8'h04;
  localparam logic [7:0]  HDR_W    = 8'h03;
  localparam logic [7:0]  FEC_W    = 8'h03;
  localparam int          MASK_N   = 15;
  localparam logic [31:0] EXT_WORD = 32'hBEDE_0000;
  localparam logic [31:0] PAD_WORD = 32'h0000_0004;
  localparam int          CLK_NS   = 100;
  localparam int          TS_TICK_NS = 10000;
  localparam int          TS_DIV   = TS_TICK_NS / CLK_NS;
  typedef enum logic [1:0] {ST_RECV = 2'b01, ST_EMIT = 2'b10} pfrf_state_t;
endpackage : pfrf_pkg
`default_nettype wire

/* File: rtl/pfrf_framer.sv */
// pfrf_framer: xor parity repair packet builder with apb control
// How it works
// - mask is 15 bits; bit i protects base plus i.
// - mask index 0 is the msb; lsb is index 14.
// - repair version is two; source packets not version two are refused.
// - repair padding flag set from control, independent of sources.
// - repair extension flag set from control, independent of sources.
// - csrc count and list name every protected source stream.
// - marker bit always sent as zero; receivers ignore it.
// - repair sequence number steps by one per packet, modulo 16 bits.
// - first repair sequence number is a random software seed.
// - repair timestamp is the time of transmission.
// - repair stream has its own random ssrc.
// - payload protects everything after the 12-byte source header.
// - source packets pass unaltered; position comes from sequence order.
// - only packets of one session's protected stream are covered.
// - ssrc collision is flagged so software can re-pick the ssrc.
// - repair cname matches the source cname; software owns it.
// - each repair packet carries an fec header after the rtp header.
// - repair content is the xor of the protected source content.
// - row mode covers L consecutive packets per repair.
// - column mode covers packets L apart per repair.
// - fec header opens with retransmit and format flags, never both set.
// - row mode gives one repair per row, D in a block.
`default_nettype none
module pfrf_framer #(
  parameter int MAX_L = 8,
  parameter int MAX_W = 64
) (
  // apb slave
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [pfrf_pkg::AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // source packet tap
  input  wire logic                   src_valid,
  input  wire logic                   src_sop,
  input  wire logic                   src_eop,
  input  wire logic [31:0]            src_data,
  output logic                        src_ready,
  // repair packet stream
  output logic                        rep_valid,
  output logic                        rep_sop,
  output logic                        rep_eop,
  output logic      [31:0]            rep_data,
  input  wire logic                   rep_ready
);
  import pfrf_pkg::*;
  localparam int LW = (MAX_L > 1) ? $clog2(MAX_L) : 1;
  localparam int PI = $clog2(MAX_W);

  logic [31:0] ctrl_reg, geom_reg, rssrc_reg, pssrc_reg, cnt_reg, ts_reg, prdata_reg;
  logic [31:0] w0_reg, w1_reg, rep_data_reg;
  logic [15:0] rseq_reg;
  logic [14:0] mask_reg;
  logic [7:0]  in_w_reg, col_reg, row_reg, ew_reg;
  logic [LW-1:0] el_reg, el_last_reg;
  logic [$clog2(TS_DIV)-1:0] tdiv_reg;
  logic        coll_reg, verr_reg, ok_reg, first_reg;
  logic        rep_valid_reg, rep_sop_reg, rep_eop_reg;
  pfrf_state_t st_reg;

  logic [13:0] hx_mem   [MAX_L];
  logic [31:0] tsx_mem  [MAX_L];
  logic [15:0] lenx_mem [MAX_L];
  logic [15:0] base_mem [MAX_L];
  logic [PI:0] maxw_mem [MAX_L];
  logic [31:0] acc_mem  [MAX_L][MAX_W];

  // apb decode
  wire logic apb_wr    = psel && penable && pwrite;
  wire logic apb_setup = psel && !penable;
  wire logic hit = (paddr == A_CTRL) || (paddr == A_GEOM) || (paddr == A_SEED) ||
                   (paddr == A_RSSRC) || (paddr == A_PSSRC) || (paddr == A_STAT) ||
                   (paddr == A_MASK) || (paddr == A_CNT);
  wire logic seed_wr = apb_wr && (paddr == A_SEED);
  wire logic stat_wr = apb_wr && (paddr == A_STAT);

  wire logic       col_mode = ctrl_reg[C_COL];
  wire logic       pad_en   = ctrl_reg[C_PAD];
  wire logic       ext_en   = ctrl_reg[C_EXT];
  wire logic [6:0] pt_val   = ctrl_reg[C_PT +: 7];
  wire logic [7:0] geo_l    = geom_reg[G_L +: 8];
  wire logic [7:0] geo_d    = geom_reg[G_D +: 8];

  // receive side
  wire logic       take     = src_valid && src_ready;
  wire logic [7:0] cur_w    = src_sop ? W_RTP0 : in_w_reg;
  wire logic [7:0] pay_w    = cur_w - HDR_W;
  wire logic [LW-1:0] lane  = col_mode ? col_reg[LW-1:0] : '0;
  wire logic       is_first = col_mode ? (row_reg == 8'h00) : (col_reg == 8'h00);
  wire logic       row_end  = (col_reg == geo_l - 8'h01);
  wire logic       blk_end  = row_end && (row_reg == geo_d - 8'h01);
  wire logic       at_ssrc  = take && (cur_w == W_SSRC);
  wire logic       ver_ok   = (w0_reg[31:30] == RTP_VER);
  wire logic       same_ses = ctrl_reg[C_EN] && (src_data == pssrc_reg);
  wire logic       hdr_ok   = ver_ok && same_ses;
  wire logic       pkt_ok   = (cur_w == W_SSRC) ? hdr_ok : ((cur_w > W_SSRC) && ok_reg);
  wire logic       first_now = (cur_w == W_SSRC) ? is_first : first_reg;
  wire logic       pay_wr   = take && ok_reg && (cur_w >= HDR_W) && (pay_w < 8'(MAX_W));
  wire logic [PI:0] cur_max = maxw_mem[lane];
  wire logic       fresh    = {1'b0, pay_w[PI-1:0]} >= cur_max;
  wire logic [15:0] len_b   = {6'h00, cur_w - 8'h02, 2'b00};
  wire logic       pkt_end  = take && src_eop && pkt_ok;
  wire logic       go_emit  = pkt_end && (col_mode ? blk_end : row_end);

  // emit side
  wire logic       emitting = (st_reg == ST_EMIT);
  wire logic       adv      = emitting && (!rep_valid_reg || rep_ready);
  wire logic [7:0] fec_at   = W_FEC0 + {7'h00, ext_en};
  wire logic [7:0] hdr_n    = fec_at + FEC_W;
  wire logic [7:0] pay_end  = hdr_n + 8'(maxw_mem[el_reg]);
  wire logic [7:0] last_w   = pay_end + {7'h00, pad_en} - 8'h01;
  wire logic       wlast    = (ew_reg == last_w);
  wire logic [7:0] pay_i    = ew_reg - hdr_n;
  wire logic       lane_end = (el_reg == el_last_reg);
  wire logic [31:0] rtp0 = {RTP_VER, pad_en, ext_en, REP_CC, 1'b0, pt_val, rseq_reg};
  // fec header with the fixed-geometry variant
  wire logic [31:0] fec0 = {FEC_RF, hx_mem[el_reg], lenx_mem[el_reg]};
  wire logic [31:0] fec2 = {base_mem[el_reg], geo_l, col_mode ? geo_d : 8'h00};
  // timestamp, own ssrc, protected ssrc as csrc
  wire logic [31:0] nxt_word =
    (ew_reg == W_RTP0)            ? rtp0 :
    (ew_reg == W_TS)              ? ts_reg :
    (ew_reg == W_SSRC)            ? rssrc_reg :
    (ew_reg == W_CSRC)            ? pssrc_reg :
    (ext_en && ew_reg == W_EXT)   ? EXT_WORD :
    (ew_reg == fec_at)            ? fec0 :
    (ew_reg == fec_at + 8'h01)    ? tsx_mem[el_reg] :
    (ew_reg == fec_at + 8'h02)    ? fec2 :
    (ew_reg < pay_end)            ? acc_mem[el_reg][pay_i[PI-1:0]] : PAD_WORD;
  // protection pattern, index 0 at the msb
  function automatic logic [14:0] mask_f(input logic cm, input logic [7:0] l,
                                         input logic [7:0] d);
    logic [14:0] m;
    int idx;
    m = '0;
    for (int k = 0; k < MASK_N; k++) begin
      idx = cm ? k * int'(l) : k;
      if ((cm ? (k < int'(d)) : (k < int'(l))) && idx < MASK_N) begin
        m[MASK_N-1-idx] = 1'b1;
      end
    end
    return m;
  endfunction : mask_f

  wire logic [31:0] stat_w = (32'(rseq_reg) << S_SEQ) | (32'(emitting) << S_BUSY) |
                             (32'(verr_reg) << S_VERR) | (32'(coll_reg) << S_COLL);
  wire logic [31:0] rd_w =
    (paddr == A_CTRL)  ? ctrl_reg :
    (paddr == A_GEOM)  ? geom_reg :
    (paddr == A_SEED)  ? 32'(rseq_reg) :
    (paddr == A_RSSRC) ? rssrc_reg :
    (paddr == A_PSSRC) ? pssrc_reg :
    (paddr == A_STAT)  ? stat_w :
    (paddr == A_MASK)  ? 32'(mask_reg) :
    (paddr == A_CNT)   ? cnt_reg : 32'h0000_0000;
  // the own ssrc seen on a source stream is a collision
  wire logic coll_set = at_ssrc && (src_data == rssrc_reg);
  // version is never rebuilt, so such sources are refused
  wire logic verr_set = at_ssrc && same_ses && !ver_ok;
  assign prdata    = prdata_reg;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !hit;
  // sources are only observed; the tap stalls while repairs go out
  assign src_ready = (st_reg == ST_RECV);
  assign rep_valid = rep_valid_reg;
  assign rep_sop   = rep_sop_reg;
  assign rep_eop   = rep_eop_reg;
  assign rep_data  = rep_data_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= 32'h0000_0000;
      geom_reg   <= 32'h0000_0000;
      rssrc_reg  <= 32'h0000_0000;
      pssrc_reg  <= 32'h0000_0000;
      prdata_reg <= 32'h0000_0000;
    end else begin
      if (apb_wr && paddr == A_CTRL) ctrl_reg <= pwdata;
      if (apb_wr && paddr == A_GEOM) geom_reg <= pwdata;
      // ssrc is a software-drawn random value, cname lives in software
      if (apb_wr && paddr == A_RSSRC) rssrc_reg <= pwdata;
      if (apb_wr && paddr == A_PSSRC) pssrc_reg <= pwdata;
      if (apb_setup) prdata_reg <= rd_w;
    end
  end
  // sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coll_reg <= 1'b0;
      verr_reg <= 1'b0;
    end else begin
      coll_reg <= coll_set | (coll_reg & ~(stat_wr & pwdata[S_COLL]));
      verr_reg <= verr_set | (verr_reg & ~(stat_wr & pwdata[S_VERR]));
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdiv_reg <= '0;
      ts_reg   <= 32'h0000_0000;
    end else if (tdiv_reg == ($clog2(TS_DIV))'(TS_DIV - 1)) begin
      tdiv_reg <= '0;
      ts_reg   <= ts_reg + 32'h0000_0001;
    end else begin
      tdiv_reg <= tdiv_reg + 1'b1;
    end
  end
  // header capture and position from sequence order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_w_reg  <= 8'h00;
      w0_reg    <= 32'h0000_0000;
      w1_reg    <= 32'h0000_0000;
      ok_reg    <= 1'b0;
      first_reg <= 1'b0;
      col_reg   <= 8'h00;
      row_reg   <= 8'h00;
    end else if (take) begin
      in_w_reg <= src_eop ? W_RTP0 : cur_w + 8'h01;
      if (cur_w == W_RTP0) w0_reg <= src_data;
      if (cur_w == W_RTP0) ok_reg <= 1'b0;
      if (cur_w == W_TS) w1_reg <= src_data;
      if (cur_w == W_SSRC) ok_reg <= hdr_ok;
      if (cur_w == W_SSRC) first_reg <= is_first;
      // column and row counters walk the block
      if (pkt_end) begin
        col_reg <= row_end ? 8'h00 : col_reg + 8'h01;
        if (row_end) row_reg <= blk_end ? 8'h00 : row_reg + 8'h01;
      end
    end
  end
  // per-lane parity, fresh words written, older ones xored
  always_ff @(posedge pclk) begin
    if (at_ssrc && hdr_ok && is_first) begin
      hx_mem[lane]   <= w0_reg[29:16];
      tsx_mem[lane]  <= w1_reg;
      base_mem[lane] <= w0_reg[15:0];
      maxw_mem[lane] <= '0;
    end else if (at_ssrc && hdr_ok) begin
      hx_mem[lane]  <= hx_mem[lane] ^ w0_reg[29:16];
      tsx_mem[lane] <= tsx_mem[lane] ^ w1_reg;
    end
    if (pay_wr) begin
      acc_mem[lane][pay_w[PI-1:0]] <= fresh ? src_data
                                            : acc_mem[lane][pay_w[PI-1:0]] ^ src_data;
      if (fresh) maxw_mem[lane] <= {1'b0, pay_w[PI-1:0]} + 1'b1;
    end
    if (pkt_end) lenx_mem[lane] <= first_now ? len_b : lenx_mem[lane] ^ len_b;
  end
  // emission sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg      <= ST_RECV;
      el_reg      <= '0;
      el_last_reg <= '0;
      ew_reg      <= 8'h00;
      mask_reg    <= 15'h0000;
    end else begin
      unique case (st_reg)
        ST_RECV: begin
          if (go_emit) begin
            st_reg      <= ST_EMIT;
            el_reg      <= '0;
            ew_reg      <= 8'h00;
            // one repair per row, or one per column in column mode
            el_last_reg <= col_mode ? LW'(geo_l - 8'h01) : '0;
            mask_reg    <= mask_f(col_mode, geo_l, geo_d);
          end
        end
        ST_EMIT: begin
          if (adv) begin
            ew_reg <= wlast ? 8'h00 : ew_reg + 8'h01;
            if (wlast && lane_end) st_reg <= ST_RECV;
            if (wlast && !lane_end) el_reg <= el_reg + 1'b1;
          end
        end
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rseq_reg <= 16'h0000;
      cnt_reg  <= 32'h0000_0000;
    end else begin
      if (seed_wr) rseq_reg <= pwdata[15:0];
      else if (adv && wlast) rseq_reg <= rseq_reg + 16'h0001;
      if (adv && wlast) cnt_reg <= cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_valid_reg <= 1'b0;
      rep_sop_reg   <= 1'b0;
      rep_eop_reg   <= 1'b0;
      rep_data_reg  <= 32'h0000_0000;
    end else if (adv) begin
      rep_valid_reg <= 1'b1;
      rep_sop_reg   <= (ew_reg == W_RTP0);
      rep_eop_reg   <= wlast;
      rep_data_reg  <= nxt_word;
    end else if (rep_ready) begin
      rep_valid_reg <= 1'b0;
    end
  end
  // helper: previous packet's sequence number for the stepping check
  logic [15:0] prev_seq_reg;
  logic        seen_reg, seeded_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_seq_reg <= 16'h0000;
      seen_reg     <= 1'b0;
      seeded_reg   <= 1'b0;
    end else begin
      if (adv && ew_reg == W_RTP0) prev_seq_reg <= rseq_reg;
      if (adv && ew_reg == W_RTP0) seen_reg <= 1'b1;
      seeded_reg <= seed_wr | (seeded_reg & ~(adv && ew_reg == W_RTP0));
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ver_field_a: assert property (rep_valid && rep_sop |-> rep_data[31:30] == RTP_VER)
    else $error("repair version not two");
  marker_zero_a: assert property (rep_valid && rep_sop |-> !rep_data[23])
    else $error("repair marker set");
  seq_step_a: assert property (adv && ew_reg == W_RTP0 && seen_reg && !seeded_reg
    |=> rep_data[15:0] == $past(prev_seq_reg) + 16'h0001)
    else $error("repair sequence did not step by one");
  csrc_count_a: assert property (rep_valid && rep_sop |->
    rep_data[27:24] == REP_CC && rep_data[29] == pad_en && rep_data[28] == ext_en)
    else $error("csrc count or flags wrong");
  fec_flags_a: assert property (adv && ew_reg == fec_at |=> rep_data[31:30] == FEC_RF)
    else $error("fec header flags wrong");
  src_stall_a: assert property (pkt_end && !go_emit |=> src_ready)
    else $error("source tap stalled outside emission");
  lane_count_a: assert property (go_emit ##1 1'b1 |->
    el_last_reg == (col_mode ? LW'(geo_l - 8'h01) : LW'(0)))
    else $error("wrong number of repair packets");
  own_ssrc_a: assert property (adv && ew_reg == W_SSRC |=> rep_data == $past(rssrc_reg))
    else $error("repair ssrc wrong");
  coll_flag_a: assert property (coll_set |=> coll_reg)
    else $error("collision not flagged");
  ver_refuse_a: assert property (verr_set |=> !ok_reg && verr_reg)
    else $error("wrong-version source accepted");

  row_emit_c: cover property (go_emit && !col_mode);
  col_emit_c: cover property (go_emit && col_mode);
  stall_c: cover property (rep_valid && !rep_ready ##1 rep_valid);
  coll_c: cover property (coll_set);
endmodule : pfrf_framer
`default_nettype wire

/* File: tb/pfrf_rep_sink.sv */
// pfrf_rep_sink: receiving endpoint model that captures repair packets
`default_nettype none
module pfrf_rep_sink #(
  parameter logic [6:0] KNOWN_PT = 7'h61
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // pacing chosen by the bench
  input  wire logic        slow,
  // repair stream
  input  wire logic        rep_valid,
  input  wire logic        rep_sop,
  input  wire logic        rep_eop,
  input  wire logic [31:0] rep_data,
  output var  logic        rep_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] words [0:255];
  int          pk_start [0:15];
  int          n_words = 0;
  int          n_pkts = 0;
  logic        keep = 1'b0;
  // the type field alone decides, the marker bit is never looked at
  wire logic   take = rep_sop ? (rep_data[22:16] == KNOWN_PT) : keep;

  // slow mode drops ready every other cycle so each beat must be held
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_ready <= 1'b0;
    end else begin
      rep_ready <= !(slow && rep_ready);
    end
  end

  always @(posedge pclk) begin
    if (presetn && rep_valid && rep_ready) begin
      keep <= take;
      if (take) begin
        words[n_words] <= rep_data;
        n_words <= n_words + 1;
      end
      if (take && rep_sop) begin
        pk_start[n_pkts] <= n_words;
      end
      if (take && rep_eop) begin
        n_pkts <= n_pkts + 1;
      end
    end
  end
endmodule : pfrf_rep_sink
`default_nettype wire

/* File: tb/pfrf_framer_bench.sv */
// pfrf_framer_bench: self-checking bench for the repair framer
`default_nettype none
module pfrf_framer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pfrf_pkg::*;
  localparam logic [6:0]  PT    = 7'h61;
  localparam logic [31:0] RSSRC = 32'h5EED_0001;
  localparam logic [31:0] PSSRC = 32'h0A0B_0C0D;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
  logic        src_valid, src_sop, src_eop, src_ready, rep_valid, rep_sop, rep_eop, rep_ready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, src_data, rep_data, rd;
  logic [13:0] sh [0:15];
  logic [31:0] st [0:15];
  logic [15:0] sn [0:15];
  int          sl [0:15];
  int          np, n_fail, n_compared;

  pfrf_framer #(.MAX_L(8), .MAX_W(64)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_valid(src_valid), .src_sop(src_sop), .src_eop(src_eop), .src_data(src_data),
    .src_ready(src_ready), .rep_valid(rep_valid), .rep_sop(rep_sop), .rep_eop(rep_eop),
    .rep_data(rep_data), .rep_ready(rep_ready));
  pfrf_rep_sink #(.KNOWN_PT(PT)) i_sink (
    .pclk(pclk), .presetn(presetn), .slow(slow), .rep_valid(rep_valid),
    .rep_sop(rep_sop), .rep_eop(rep_eop), .rep_data(rep_data), .rep_ready(rep_ready));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic complete_run();
    if (n_fail == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // request held until the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t apb ready timeout", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] pay(input int p, input int k);
    return {8'(p), 8'h5C, 8'(k), 8'hC3};
  endfunction : pay

  // entered just after an edge; each word waits for an edge with src_ready high
  task automatic send_pkt(input logic [1:0] v, input logic [31:0] ssrc, input int len);
    int k;
    int n;
    sh[np] = 14'h00A5 ^ 14'(np * 14'h0123);
    st[np] = 32'h1000_0000 + 32'(np * 77);
    sn[np] = 16'h7FF0 + 16'(np);
    sl[np] = len;
    for (k = 0; k < len + 3; k++) begin
      src_valid <= 1'b1;
      src_sop <= (k == 0);
      src_eop <= (k == len + 2);
      src_data <= k == 0 ? {v, sh[np], sn[np]} : k == 1 ? st[np] : k == 2 ? ssrc : pay(np, k - 3);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (src_ready !== 1'b1 && n < 500);
      if (src_ready !== 1'b1) begin
        n_fail++;
        $display("[ERR] %0t source word not taken", $time);
      end
    end
    src_valid <= 1'b0;
    src_sop <= 1'b0;
    src_eop <= 1'b0;
    np++;
    // one idle edge so a following packet never re-raises valid in this step
    @(posedge pclk);
  endtask : send_pkt

  task automatic wait_pkts(input int want);
    int c;
    c = 0;
    while (i_sink.n_pkts < want && c < 3000) begin
      @(posedge pclk);
      c++;
    end
    chk(32'(i_sink.n_pkts), 32'(want), "repair count");
  endtask : wait_pkts

  task automatic check_rep(input int r, input int a, input int b, input logic pad,
                           input logic ext, input logic [15:0] seq, input logic [7:0] d);
    int s;
    int o;
    int m;
    int k;
    logic [31:0] w;
    s = i_sink.pk_start[r];
    o = int'(ext);
    m = sl[a] > sl[b] ? sl[a] : sl[b];
    w = {2'h2, pad, ext, 4'h1, 1'b0, PT, seq};
    chk(i_sink.words[s], w, "rtp word");
    chk(i_sink.words[s + 2], RSSRC, "repair ssrc");
    chk(i_sink.words[s + 3], PSSRC, "csrc");
    if (ext) begin
      chk(i_sink.words[s + 4], EXT_WORD, "ext word");
    end
    w = {2'h1, sh[a] ^ sh[b], 16'(4 * sl[a]) ^ 16'(4 * sl[b])};
    chk(i_sink.words[s + 4 + o], w, "fec word");
    chk(i_sink.words[s + 5 + o], st[a] ^ st[b], "ts recovery");
    chk(i_sink.words[s + 6 + o], {sn[a], 8'h02, d}, "block word");
    for (k = 0; k < m; k++) begin
      w = k < sl[a] ? pay(a, k) : 32'h0;
      w = w ^ (k < sl[b] ? pay(b, k) : 32'h0);
      chk(i_sink.words[s + 7 + o + k], w, "payload");
    end
    if (pad) begin
      chk(i_sink.words[s + 7 + o + m], PAD_WORD, "pad word");
    end
  endtask : check_rep

  task automatic t_regs();
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b1, A_GEOM, 32'h0000_0202);
    apb(1'b0, A_GEOM, 32'h0);
    chk(rd, 32'h0000_0202, "geom");
    apb(1'b1, A_SEED, 32'h0000_FFFF);
    apb(1'b1, A_RSSRC, RSSRC);
    apb(1'b1, A_PSSRC, PSSRC);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1, "slverr");
    chk(rd, 32'h0, "unmapped read");
  endtask : t_regs

  // row mode with the sink stalling; seed at the top so the count wraps
  task automatic t_row();
    slow <= 1'b1;
    apb(1'b1, A_CTRL, {17'h0, PT, 8'h01});
    send_pkt(2'h2, PSSRC, 3);
    send_pkt(2'h2, PSSRC, 1);
    send_pkt(2'h2, PSSRC, 2);
    send_pkt(2'h2, PSSRC, 2);
    wait_pkts(2);
    check_rep(0, 0, 1, 1'b0, 1'b0, 16'hFFFF, 8'h00);
    check_rep(1, 2, 3, 1'b0, 1'b0, 16'h0000, 8'h00);
    slow <= 1'b0;
  endtask : t_row

  // a pair that would form a row if both were accepted
  task automatic t_refuse();
    send_pkt(2'h1, PSSRC, 1);
    // foreign session that also reuses the repair stream's own ssrc
    send_pkt(2'h2, RSSRC, 1);
    repeat (30) @(posedge pclk);
    chk(32'(i_sink.n_pkts), 32'h2, "refused packets");
    apb(1'b0, A_STAT, 32'h0);
    chk({31'h0, rd[S_VERR]}, 32'h1, "verr set");
    chk({31'h0, rd[S_COLL]}, 32'h1, "coll set");
    apb(1'b1, A_STAT, 32'h0000_0002);
    apb(1'b0, A_STAT, 32'h0);
    chk({31'h0, rd[S_VERR]}, 32'h0, "verr cleared");
  endtask : t_refuse

  task automatic t_col();
    repeat (150) @(posedge pclk);
    apb(1'b1, A_CTRL, {17'h0, PT, 8'h0F});
    send_pkt(2'h2, PSSRC, 1);
    send_pkt(2'h2, PSSRC, 2);
    send_pkt(2'h2, PSSRC, 3);
    send_pkt(2'h2, PSSRC, 1);
    wait_pkts(4);
    check_rep(2, 6, 8, 1'b1, 1'b1, 16'h0001, 8'h02);
    check_rep(3, 7, 9, 1'b1, 1'b1, 16'h0002, 8'h02);
    rd = i_sink.words[i_sink.pk_start[2] + 1];
    chk({31'h0, rd != i_sink.words[1]}, 32'h1, "repair ts moves");
    apb(1'b0, A_CNT, 32'h0);
    chk(rd, 32'h4, "repair counter");
    apb(1'b0, A_MASK, 32'h0);
    chk(rd, 32'h0000_5000, "column mask");
    apb(1'b0, A_SEED, 32'h0);
    chk(rd, 32'h0000_0003, "next repair seq");
  endtask : t_col

  initial begin
    #2000000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    src_valid = 1'b0;
    src_sop = 1'b0;
    src_eop = 1'b0;
    src_data = 32'h0;
    slow = 1'b0;
    np = 0;
    n_fail = 0;
    n_compared = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_row();
    t_refuse();
    t_col();
    complete_run();
  end
endmodule : pfrf_framer_bench
`default_nettype wire
